// ===== bench/pixel_source.sv
`timescale 1ns/1ps
module pixel_source (
   input  wire logic        clk_i,
   input  wire logic        en_i,
   input  wire logic        ready_i,
   output logic             valid_o,
   output logic [23:0]      data_o,
   output logic [7:0]       taken_o
);
   initial begin
      valid_o = 1'b0;
      data_o = 24'h123456;
      taken_o = 8'h00;
   end
   // word held until taken, even if enable drops; idle data toggles
   always @(posedge clk_i) begin
      if (valid_o && ready_i) taken_o <= taken_o + 8'h01;
      valid_o <= #1 en_i || (valid_o && !ready_i);
      data_o <= #1 (valid_o && !ready_i) ? data_o : ~data_o;
   end
endmodule : pixel_source

// ===== bench/test_video_chroma_nco_caption_insert.sv
`timescale 1ns/1ps
module test_video_chroma_nco_caption_insert;
   import video_encoder_pkg::*;
   logic        clk, rst, wr, wr_line, wr_high, anc_v, line_st, src_en, pv, pr;
   logic [1:0]  cc_en, status;
   logic [7:0]  wr_data, anc_id, taken;
   logic [15:0] anc_data;
   logic [9:0]  ctl, line_num, luma, chroma, comp;
   logic [23:0] pd;
   standard_type    std;
   step_source_type step_src;
   int          n_fail = 0, num_checks = 0;
   // rows: enables, line written, both bytes, expected status
   typedef struct {logic [1:0] en; logic ln; logic both; logic [1:0] st;} row_type;
   row_type rows [5] = '{'{2'h1,1'b0,1'b1,2'h2}, '{2'h0,1'b0,1'b1,2'h3},
      '{2'h2,1'b1,1'b1,2'h1}, '{2'h3,1'b0,1'b0,2'h3}, '{2'h1,1'b1,1'b1,2'h3}};
   pixel_source u_src (.clk_i(clk), .en_i(src_en), .ready_i(pr), .valid_o(pv), .data_o(pd),
      .taken_o(taken));
   video_chroma_nco_caption_insert u_dut (.CLK_I(clk), .RST_I(rst), .STANDARD_I(std),
      .LUMA_FILTER_EN_I(ctl[0]), .LIMIT_EN_I(ctl[1]), .PEDESTAL_EN_I(ctl[2]),
      .STEP_SOURCE_I(step_src), .STEP_REG_I({2{anc_data}}), .ANC_STEP_VALID_I(ctl[9]),
      .ANC_STEP_I({anc_data, anc_data}), .PHASE_RESET_EN_I(ctl[3]), .FIELD_START_I(ctl[4]),
      .LINE_START_I(line_st), .LINE_NUM_I(line_num), .HSYNC_I(ctl[5]), .VSYNC_I(ctl[6]),
      .BURST_I(ctl[7]), .ACTIVE_I(ctl[8]), .PIX_VALID_I(pv), .PIX_READY_O(pr),
      .PIX_DATA_I(pd), .CC_ENABLE_I(cc_en), .CC_WR_I(wr), .CC_WR_LINE_I(wr_line),
      .CC_WR_HIGH_I(wr_high), .CC_WR_DATA_I(wr_data), .ANC_CC_VALID_I(anc_v),
      .ANC_CC_ID_I(anc_id), .ANC_CC_DATA_I(anc_data), .CC_STATUS_O(status),
      .LUMA_O(luma), .CHROMA_O(chroma), .COMPOSITE_O(comp));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   // reset held ten cycles, inputs move 1 ns after the edge
   task automatic rst_dut();
      @(posedge clk) #1 rst = 1'b1;
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
   endtask : rst_dut
   task automatic wr_b(input logic ln, input logic hi, input logic [7:0] d);
      @(posedge clk) #1 {wr, wr_line, wr_high, wr_data} = {1'b1, ln, hi, d};
      @(posedge clk) #1 wr = 1'b0;
   endtask : wr_b
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // watchdog: whole run needs about 1700 cycles
   initial begin
      #(5000 * 100);
      n_fail++;
      print_verdict();
   end
   initial begin
      {wr, wr_line, wr_high, anc_v, line_st, src_en, cc_en, wr_data} = '0;
      {anc_id, anc_data, line_num, ctl} = '0;
      rst = 1'b1;
      std = STD_NTSC;
      step_src = STEP_TABLE;
      rst_dut();
      chk(comp, 10'h0f0);
      chk({chroma, luma}, {10'h200, 10'h0f0});
      foreach (rows[i]) begin
         rst_dut();
         cc_en = rows[i].en;
         wr_b(rows[i].ln, 1'b1, 8'ha5);
         if (rows[i].both) wr_b(rows[i].ln, 1'b0, 8'h5a);
         @(posedge clk) #1 chk(status, rows[i].st);
      end
      // parity bits set in the id byte must not matter
      rst_dut();
      cc_en = 2'h3;
      @(posedge clk) #1 {anc_v, anc_id, anc_data} = {1'b1, 8'hc1, 16'h0001};
      @(posedge clk) #1 anc_v = 1'b0;
      @(posedge clk) #1 chk(status, 2'h1);
      // register step, cleared on every fourth field start
      step_src = STEP_REGISTER;
      ctl = 10'h008;
      repeat (8) begin
         @(posedge clk) #1 ctl = 10'h018;
         @(posedge clk) #1 ctl = 10'h008;
      end
      // phase reset off at the edge the ancillary step is chosen
      @(posedge clk) #1 ctl = 10'h200;
      step_src = STEP_ANCILLARY;
      @(posedge clk) #1 ctl = 10'h000;
      // fifo fills to eight words with active video low
      src_en = 1'b1;
      repeat (20) @(posedge clk);
      #1 chk({taken, 7'h00, pr}, {8'h08, 8'h00});
      src_en = 1'b0;
      rst_dut();
      cc_en = 2'h1;
      ctl = 10'h102;
      // both host bytes loaded well before the line
      wr_b(1'b0, 1'b0, 8'h01);
      wr_b(1'b0, 1'b1, 8'h00);
      // active video high, so pixels must be ignored; pass two is another standard
      for (int p = 0; p < 2; p++) begin
         std = p ? STD_PAL_M : STD_NTSC;
         @(posedge clk) #1 {line_st, line_num} = {1'b1, p ? 10'd18 : 10'd21};
         @(posedge clk) #1 line_st = 1'b0;
         repeat (105 + 17 * 19 + 8) @(posedge clk);
         #1 chk(comp, 10'h1a0);
         chk(luma, 10'h1a0);
         repeat (19) @(posedge clk);
         #1 chk(comp, 10'h0f0);
         chk(chroma, 10'h200);
         repeat (320) @(posedge clk);
         #1 chk(status, 2'h3);
      end
      print_verdict();
   end
endmodule : test_video_chroma_nco_caption_insert

// ===== inc/video_encoder_pkg.sv
package video_encoder_pkg;
   // video standards served by the back end
   typedef enum logic [1:0] {STD_NTSC, STD_PAL_M, STD_PAL_OTHER} standard_type;
   // phase step sources
   typedef enum logic [1:0] {STEP_TABLE, STEP_ANCILLARY, STEP_REGISTER} step_source_type;

   // clock timing
   localparam int CLK_FREQ_HZ   = 10_000_000;
   localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
   // caption edge: least 240 ns, rounded up
   localparam int CC_EDGE_NS    = 240;
   localparam int EDGE_CYCLES   = (CC_EDGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // caption bit period and start delay after line start
   localparam int CC_BIT_NS     = 1986;
   localparam int CC_BIT_CYCLES = CC_BIT_NS / CLK_PERIOD_NS;
   localparam int CC_START_NS   = 10500;
   localparam int CC_START_CYC  = CC_START_NS / CLK_PERIOD_NS;
   // caption frame: run-in, start bits, data
   localparam int CC_RUNIN_BITS = 14;
   localparam int CC_START_BITS = 3;
   localparam int CC_DATA_BITS  = 16;
   localparam int CC_FRAME_BITS = CC_RUNIN_BITS + CC_START_BITS + CC_DATA_BITS;
   localparam logic [13:0] CC_RUNIN   = 14'h1555;
   localparam logic [2:0]  CC_STARTS  = 3'h4;
   // caption lines per standard, first and second register
   localparam logic [9:0] CC_LINE_A_NTSC  = 10'h015;
   localparam logic [9:0] CC_LINE_B_NTSC  = 10'h11c;
   localparam logic [9:0] CC_LINE_A_PALM  = 10'h012;
   localparam logic [9:0] CC_LINE_B_PALM  = 10'h119;
   localparam logic [9:0] CC_LINE_A_PAL   = 10'h016;
   localparam logic [9:0] CC_LINE_B_PAL   = 10'h14f;
   // field-to-burst-phase sequence lengths
   localparam logic [2:0] SEQ_LAST_NTSC = 3'h3;
   localparam logic [2:0] SEQ_LAST_PAL  = 3'h7;
   // internal phase steps, subcarrier over clock times two to the 32
   localparam logic [31:0] STEP_NTSC = 32'h21f07c1f;
   localparam logic [31:0] STEP_PALM = 32'h21e6efe3;
   localparam logic [31:0] STEP_PAL  = 32'h2a098acb;
   // output levels, 10-bit code
   localparam logic signed [12:0] LEVEL_BLANK    = 13'sh0f0;
   localparam logic signed [12:0] LEVEL_SYNC     = 13'sh010;
   localparam logic signed [12:0] CC_HIGH_DELTA  = 13'sh0b0;
   localparam logic signed [12:0] PEDESTAL_DELTA = 13'sh01a;
   localparam logic signed [12:0] LIMIT_FLOOR    = 13'sh080;
   localparam logic signed [12:0] CODE_MAX       = 13'sh3ff;
   // luma and subcarrier prescale per standard, sixty-fourths
   localparam logic [7:0] LUMA_SCALE_NTSC = 8'h6c;
   localparam logic [7:0] LUMA_SCALE_PAL  = 8'h70;
   localparam logic [7:0] SINE_SCALE_NTSC = 8'h40;
   localparam logic [7:0] SINE_SCALE_PAL  = 8'h44;
   // raised-cosine gain steps, sixteenths
   localparam logic [4:0] RC_GAIN_1 = 5'h02;
   localparam logic [4:0] RC_GAIN_2 = 5'h08;
   localparam logic [4:0] RC_GAIN_3 = 5'h0e;
   localparam logic [4:0] RC_GAIN_4 = 5'h10;
endpackage : video_encoder_pkg

// ===== rtl/video_chroma_nco_caption_insert.sv
// Behaviour
// - luma lowpass unless bypassed, scaled per standard
// - chroma lowpass always, no bypass
// - accumulator advances every clock, addresses sine
// - phase step from table, ancillary, or register
// - top accumulator bits address sine table
// - prescaled sine modulates filtered chroma
// - accumulator starts at zero after reset
// - optional clear every 4/8 fields
// - composite sums luma, chroma, sync, burst, pedestal
// - optional clamp of composite active video above eighth, luma output not clamped
// - shaped transitions on all listed edges
// - caption on standard lines, pixels ignored
// - caption line: run-in, start bits, data
// - two 16-bit registers on standard lines
// - caption data shifted out LSB first
// - one 50 IRE, zero 0, raised-cosine edges
// - stale register is retransmitted unchanged
// - write status cleared on load, set after output
// - each caption line enabled independently
// - ancillary line bit picks register, parity ignored
`timescale 1ns/1ps
module pixel_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   // pointer wrap needs a power-of-two depth
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] store [DEPTH];   // word storage
   logic [AW:0]      wr_ptr;          // extra bit tells full from empty
   logic [AW:0]      rd_ptr;
   wire              push = in_valid_i && in_ready_o;
   wire              pop  = out_valid_o && out_ready_i;
   assign in_ready_o  = (wr_ptr ^ rd_ptr) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_ptr != rd_ptr;
   assign out_data_o  = store[rd_ptr[AW-1:0]];
   // pointers move only on accepted transfers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
      end
   end
   // storage has no reset, only written words are read
   always_ff @(posedge clk_i) begin
      if (push) store[wr_ptr[AW-1:0]] <= in_data_i;
   end
endmodule : pixel_fifo

module video_chroma_nco_caption_insert #(
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic                                 CLK_I,
   input  wire logic                                 RST_I,
   input  wire video_encoder_pkg::standard_type      STANDARD_I,
   input  wire logic                                 LUMA_FILTER_EN_I,
   input  wire logic                                 LIMIT_EN_I,
   input  wire logic                                 PEDESTAL_EN_I,
   input  wire video_encoder_pkg::step_source_type   STEP_SOURCE_I,
   input  wire logic [31:0]                          STEP_REG_I,
   input  wire logic                                 ANC_STEP_VALID_I,
   input  wire logic [31:0]                          ANC_STEP_I,
   input  wire logic                                 PHASE_RESET_EN_I,
   input  wire logic                                 FIELD_START_I,
   input  wire logic                                 LINE_START_I,
   input  wire logic [9:0]                           LINE_NUM_I,
   input  wire logic                                 HSYNC_I,
   input  wire logic                                 VSYNC_I,
   input  wire logic                                 BURST_I,
   input  wire logic                                 ACTIVE_I,
   input  wire logic                                 PIX_VALID_I,
   output logic                                      PIX_READY_O,
   input  wire logic [23:0]                          PIX_DATA_I,
   input  wire logic [1:0]                           CC_ENABLE_I,
   input  wire logic                                 CC_WR_I,
   input  wire logic                                 CC_WR_LINE_I,
   input  wire logic                                 CC_WR_HIGH_I,
   input  wire logic [7:0]                           CC_WR_DATA_I,
   input  wire logic                                 ANC_CC_VALID_I,
   input  wire logic [7:0]                           ANC_CC_ID_I,
   input  wire logic [15:0]                          ANC_CC_DATA_I,
   output logic [1:0]                                CC_STATUS_O,
   output logic [9:0]                                LUMA_O,
   output logic [9:0]                                CHROMA_O,
   output logic [9:0]                                COMPOSITE_O
);
   import video_encoder_pkg::*;
   // refuse a fifo too shallow to cover one pixel of slack
   if (FIFO_DEPTH < 2) begin : g_bad_fifo
      $error("fifo depth too small");
   end

   // pixel path: fifo drained at half clock rate
   logic        half_tick;             // pixel-rate enable
   logic        pix_valid;
   logic [23:0] pix_data;
   logic [23:0] pix_hold;               // last pixel, repeated on idle ticks
   wire         pix_pop = half_tick && ACTIVE_I;
   pixel_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i       (CLK_I),
      .rst_i       (RST_I),
      .in_valid_i  (PIX_VALID_I),
      .in_ready_o  (PIX_READY_O),
      .in_data_i   (PIX_DATA_I),
      .out_valid_o (pix_valid),
      .out_ready_i (pix_pop),
      .out_data_o  (pix_data)
   );
   // divider and pixel hold; last pixel repeated when starved, blank level after reset
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         half_tick <= 1'b0;
         pix_hold  <= 24'h108080;
      end else begin
         half_tick <= !half_tick;
         if (pix_pop && pix_valid) pix_hold <= pix_data;
      end
   end

   // luma and chroma filters
   logic [7:0]  y_d1, y_d2;            // luma taps
   logic [9:0]  cb_sum, cr_sum;         // chroma running sums
   logic [7:0]  cb_d [3];
   logic [7:0]  cr_d [3];
   wire  [7:0]  y_in  = pix_hold[23:16];
   wire  [7:0]  cb_in = pix_hold[15:8];
   wire  [7:0]  cr_in = pix_hold[7:0];
   wire  [9:0]  y_taps = {2'h0, y_in} + {1'b0, y_d1, 1'b0} + {2'h0, y_d2};
   wire  [7:0]  y_filt = LUMA_FILTER_EN_I ? y_taps[9:2] : y_d1;
   wire  [9:0]  next_cb_sum = {2'h0, cb_in} + {2'h0, cb_d[0]} + {2'h0, cb_d[1]} + {2'h0, cb_d[2]};
   wire  [9:0]  next_cr_sum = {2'h0, cr_in} + {2'h0, cr_d[0]} + {2'h0, cr_d[1]} + {2'h0, cr_d[2]};
   always_ff @(posedge CLK_I) begin
      y_d1 <= y_in;
      y_d2 <= y_d1;
      cb_d <= '{cb_in, cb_d[0], cb_d[1]};
      cr_d <= '{cr_in, cr_d[0], cr_d[1]};
      cb_sum <= next_cb_sum;
      cr_sum <= next_cr_sum;
   end
   wire signed [8:0] cb_f = $signed({1'b0, cb_sum[9:2]}) - 9'sd128;
   wire signed [8:0] cr_f = $signed({1'b0, cr_sum[9:2]}) - 9'sd128;
   wire [7:0]  luma_scale = (STANDARD_I == STD_PAL_OTHER) ? LUMA_SCALE_PAL : LUMA_SCALE_NTSC;
   wire signed [17:0] y_scaled = ($signed({1'b0, y_filt}) - 18'sd16) * $signed({1'b0, luma_scale});
   wire signed [12:0] y_delta = 13'(y_scaled >>> 6);

   // oscillator: phase step select and accumulator
   logic [31:0] subcarrier_phase_accum;
   logic [31:0] anc_step;               // last received ancillary step
   logic [2:0]  field_count;            // position in burst-phase sequence
   wire  [31:0] table_step = (STANDARD_I == STD_NTSC)  ? STEP_NTSC :
                             (STANDARD_I == STD_PAL_M) ? STEP_PALM : STEP_PAL;
   wire  [31:0] subcarrier_phase_step = (STEP_SOURCE_I == STEP_ANCILLARY) ? anc_step :
                                        (STEP_SOURCE_I == STEP_REGISTER)  ? STEP_REG_I :
                                                                            table_step;
   wire  [2:0]  seq_last = (STANDARD_I == STD_NTSC) ? SEQ_LAST_NTSC : SEQ_LAST_PAL;
   wire         seq_begin = FIELD_START_I && (field_count == seq_last);
   // clear at sequence start when enabled
   wire         phase_clear = seq_begin && PHASE_RESET_EN_I;
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         subcarrier_phase_accum <= '0;
         anc_step    <= STEP_NTSC;
         field_count <= '0;
      end else begin
         if (ANC_STEP_VALID_I) anc_step <= ANC_STEP_I;
         if (FIELD_START_I) field_count <= seq_begin ? 3'h0 : field_count + 3'h1;
         subcarrier_phase_accum <= phase_clear ? 32'h0 : subcarrier_phase_accum + subcarrier_phase_step;
      end
   end

   // quarter-wave sine table
   function automatic logic signed [8:0] sine_of(input logic [4:0] addr);
      logic [6:0] mag;
      logic [2:0] idx;
      idx = addr[3] ? ~addr[2:0] : addr[2:0];
      unique case (idx)
         3'h0: mag = 7'd12;
         3'h1: mag = 7'd37;
         3'h2: mag = 7'd60;
         3'h3: mag = 7'd81;
         3'h4: mag = 7'd98;
         3'h5: mag = 7'd112;
         3'h6: mag = 7'd122;
         3'h7: mag = 7'd127;
      endcase
      return addr[4] ? -$signed({2'b0, mag}) : $signed({2'b0, mag});
   endfunction : sine_of
   // top five bits address the table
   wire [4:0] sine_addr = subcarrier_phase_accum[31:27];
   wire [4:0] cos_addr  = sine_addr + 5'h08;
   wire [7:0] sine_scale = (STANDARD_I == STD_PAL_OTHER) ? SINE_SCALE_PAL : SINE_SCALE_NTSC;
   wire signed [17:0] sine_s = (sine_of(sine_addr) * $signed({1'b0, sine_scale})) >>> 6;
   wire signed [17:0] cos_s  = (sine_of(cos_addr) * $signed({1'b0, sine_scale})) >>> 6;
   wire signed [27:0] chroma_mod = cb_f * sine_s + cr_f * cos_s;
   wire signed [12:0] c_delta = 13'(chroma_mod >>> 8);
   wire signed [12:0] burst_amp = 13'(sine_s >>> 1);

   // caption registers, status and line select
   logic [15:0] cc_data [2];            // held until overwritten, resent if stale
   logic [1:0]  cc_written [2];         // low and high byte written
   logic [1:0]  cc_loaded;              // status zero, loaded and waiting
   logic        cc_line;                // current line carries caption
   logic        cc_sel;                 // register being sent
   logic        cc_done;                // one-cycle pulse after last bit
   wire  [9:0]  line_a = (STANDARD_I == STD_NTSC)  ? CC_LINE_A_NTSC :
                          (STANDARD_I == STD_PAL_M) ? CC_LINE_A_PALM : CC_LINE_A_PAL;
   wire  [9:0]  line_b = (STANDARD_I == STD_NTSC)  ? CC_LINE_B_NTSC :
                          (STANDARD_I == STD_PAL_M) ? CC_LINE_B_PALM : CC_LINE_B_PAL;
   wire         hit_a = LINE_START_I && CC_ENABLE_I[0] && (LINE_NUM_I == line_a);
   wire         hit_b = LINE_START_I && CC_ENABLE_I[1] && (LINE_NUM_I == line_b);
   // bit zero of data id picks register, parity bits unused
   wire         anc_line = ANC_CC_ID_I[0];
   assign CC_STATUS_O = ~cc_loaded;

   // per-line register, byte tracking and status
   for (genvar l = 0; l < 2; l++) begin : g_cc_reg
      wire host_wr = CC_WR_I && (CC_WR_LINE_I == 1'(l));
      wire anc_wr  = ANC_CC_VALID_I && (anc_line == 1'(l));
      wire [1:0] next_written = anc_wr ? 2'h3 :
                                cc_written[l] | (host_wr ? {CC_WR_HIGH_I, !CC_WR_HIGH_I} : 2'h0);
      wire sent = cc_done && (cc_sel == 1'(l));
      always_ff @(posedge CLK_I) begin
         if (RST_I) begin
            cc_data[l]    <= '0;
            cc_written[l] <= '0;
            cc_loaded[l]  <= 1'b0;
         end else begin
            // bytes in any order, ancillary loads both
            if (anc_wr) cc_data[l] <= ANC_CC_DATA_I;
            else if (host_wr && CC_WR_HIGH_I) cc_data[l][15:8] <= CC_WR_DATA_I;
            else if (host_wr) cc_data[l][7:0] <= CC_WR_DATA_I;
            cc_written[l] <= (next_written == 2'h3 && CC_ENABLE_I[l]) ? 2'h0 : next_written;
            // set after output wins over a new load
            if (!CC_ENABLE_I[l] || sent) cc_loaded[l] <= 1'b0;
            else if (next_written == 2'h3) cc_loaded[l] <= 1'b1;
         end
      end
   end

   // caption serializer
   typedef enum logic [1:0] {CC_IDLE, CC_WAIT, CC_SEND} cc_state_type;
   cc_state_type cc_state;
   logic [11:0]  cc_timer;              // cycles left in delay or bit
   logic [5:0]   cc_bit;                // frame bit index
   // frame of run-in, starts, stored data
   wire  [CC_FRAME_BITS-1:0] cc_frame = {cc_data[cc_sel], CC_STARTS, CC_RUNIN};
   wire          cc_level = (cc_state == CC_SEND) && cc_frame[cc_bit];
   wire          timer_end = cc_timer == 12'h0;
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         cc_state <= CC_IDLE;
         cc_timer <= '0;
         cc_bit   <= '0;
         cc_sel   <= 1'b0;
         cc_line  <= 1'b0;
         cc_done  <= 1'b0;
      end else begin
         cc_done <= 1'b0;
         if (LINE_START_I) cc_line <= hit_a || hit_b;
         unique case (cc_state)
            CC_IDLE: begin
               if (hit_a || hit_b) begin
                  cc_sel   <= hit_b;
                  cc_timer <= 12'(CC_START_CYC - 1);
                  cc_state <= CC_WAIT;
               end
            end
            CC_WAIT: begin
               if (timer_end) begin
                  cc_bit   <= '0;
                  cc_timer <= 12'(CC_BIT_CYCLES - 1);
                  cc_state <= CC_SEND;
               end else cc_timer <= cc_timer - 12'h1;
            end
            CC_SEND: begin
               if (!timer_end) cc_timer <= cc_timer - 12'h1;
               else if (cc_bit == 6'(CC_FRAME_BITS - 1)) begin
                  cc_done  <= 1'b1;
                  cc_state <= CC_IDLE;
               end else begin
                  cc_bit   <= cc_bit + 6'h1;
                  cc_timer <= 12'(CC_BIT_CYCLES - 1);
               end
            end
         endcase
      end
   end

   // edge shapers: hsync, vsync interval, burst, active, caption
   localparam int EDGES = 5;
   wire  [EDGES-1:0] edge_target = {cc_level, ACTIVE_I && !cc_line, BURST_I, VSYNC_I, HSYNC_I};
   logic [4:0]       edge_gain [EDGES];
   for (genvar e = 0; e < EDGES; e++) begin : g_edge
      logic [1:0] pos;                  // ramp position
      always_ff @(posedge CLK_I) begin
         if (RST_I) pos <= '0;
         else if (edge_target[e] && pos != 2'(EDGE_CYCLES)) pos <= pos + 2'h1;
         else if (!edge_target[e] && pos != 2'h0) pos <= pos - 2'h1;
      end
      assign edge_gain[e] = (pos == 2'h0) ? 5'h00 : (pos == 2'h1) ? RC_GAIN_1 :
                            (pos == 2'h2) ? RC_GAIN_2 : (pos == 2'h3) ? RC_GAIN_4 : RC_GAIN_3;
   end

   // composite sum
   wire [4:0] sync_gain = (edge_gain[0] > edge_gain[1]) ? edge_gain[0] : edge_gain[1];
   wire signed [12:0] ped = PEDESTAL_EN_I ? PEDESTAL_DELTA : 13'sh0;
   wire signed [17:0] act_t  = (y_delta + ped + c_delta) * $signed({1'b0, edge_gain[3]});
   wire signed [17:0] bur_t  = burst_amp * $signed({1'b0, edge_gain[2]});
   // fifty IRE scaled by caption edge
   wire signed [17:0] cc_t   = CC_HIGH_DELTA * $signed({1'b0, edge_gain[4]});
   wire signed [17:0] sync_t = (LEVEL_BLANK - LEVEL_SYNC) * $signed({1'b0, sync_gain});
   wire signed [12:0] comp_sum = LEVEL_BLANK + 13'(act_t >>> 4) + 13'(bur_t >>> 4)
                                 + 13'(cc_t >>> 4) - 13'(sync_t >>> 4);
   wire               clamp = LIMIT_EN_I && edge_gain[3] != 5'h0 && sync_gain == 5'h0;
   wire signed [12:0] comp_lim = (clamp && comp_sum < LIMIT_FLOOR) ? LIMIT_FLOOR : comp_sum;
   wire signed [12:0] comp_sat = (comp_lim < 0) ? 13'sh0 : (comp_lim > CODE_MAX) ? CODE_MAX : comp_lim;
   wire signed [12:0] luma_sum = LEVEL_BLANK + 13'(act_t >>> 4) - 13'(c_delta * $signed({1'b0, edge_gain[3]}) >>> 4)
                                 + 13'(cc_t >>> 4) - 13'(sync_t >>> 4);
   wire signed [12:0] luma_sat = (luma_sum < 0) ? 13'sh0 : (luma_sum > CODE_MAX) ? CODE_MAX : luma_sum;
   wire signed [12:0] chroma_sum = 13'sh200 + 13'((c_delta * $signed({1'b0, edge_gain[3]})) >>> 4) + 13'(bur_t >>> 4);
   // registered outputs
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         COMPOSITE_O <= LEVEL_BLANK[9:0];
         LUMA_O      <= LEVEL_BLANK[9:0];
         CHROMA_O    <= 10'h200;
      end else begin
         COMPOSITE_O <= comp_sat[9:0];
         LUMA_O      <= luma_sat[9:0];
         CHROMA_O    <= chroma_sum[9:0];
      end
   end

   // cycles spent in one send; restarts whenever the serializer leaves it
   logic [9:0] send_cycles;
   wire        frame_full = send_cycles == 10'(CC_FRAME_BITS * CC_BIT_CYCLES);
   always_ff @(posedge CLK_I) begin
      if (RST_I || cc_state != CC_SEND) send_cycles <= '0;
      else send_cycles <= send_cycles + 10'h1;
   end

   // checks
   default clocking cb_main @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   sequence s_seq_start; FIELD_START_I && field_count == seq_last && PHASE_RESET_EN_I; endsequence
   sequence s_cc_go; cc_state == CC_IDLE && hit_a && !hit_b; endsequence
   AST_STEP_ADVANCE: assert property (!phase_clear |=> subcarrier_phase_accum == 32'($past(subcarrier_phase_accum) + $past(subcarrier_phase_step))) else $error("accumulator did not advance");
   AST_PHASE_CLEAR: assert property (s_seq_start |=> subcarrier_phase_accum == 32'h0) else $error("phase not cleared at sequence start");
   AST_NO_CLEAR_OFF: assert property (!PHASE_RESET_EN_I && subcarrier_phase_step != 0 |=> subcarrier_phase_accum != $past(subcarrier_phase_accum)) else $error("accumulator stalled");
   AST_REG_SOURCE: assert property (STEP_SOURCE_I == STEP_REGISTER |-> subcarrier_phase_step == STEP_REG_I) else $error("wrong step source");
   AST_STATUS_OFF: assert property (!CC_ENABLE_I[0] |=> CC_STATUS_O[0]) else $error("status not one when disabled");
   AST_STATUS_SET: assert property (cc_done && cc_sel == 1'b0 |=> CC_STATUS_O[0]) else $error("status not set after output");
   AST_CC_START: assert property (s_cc_go |=> cc_state == CC_WAIT ##(CC_START_CYC) cc_state == CC_SEND && cc_bit == 0) else $error("caption start delay wrong");
   AST_CC_LENGTH: assert property (cc_done |-> frame_full) else $error("caption frame length wrong");
   AST_PIX_IGNORED: assert property (cc_line [*4] |-> edge_gain[3] == 5'h0) else $error("pixels not ignored on caption line");
   AST_CLAMP: assert property (LIMIT_EN_I && edge_gain[3] == RC_GAIN_4 && sync_gain == 0 |=> $signed({3'b0, COMPOSITE_O}) >= LIMIT_FLOOR) else $error("active video below floor");
endmodule : video_chroma_nco_caption_insert
